// file: common/sdf_pkg.sv
// Constants shared by the self-test sequencer and the controller.
// Assumes one 50 MHz clock and an active-low asynchronous reset.
// Contract
// - Controller holds shared reset until its tests end
// - Fault indicator lit from power-up until sequence ends
// - Init watchdog, serial format, peripheral defaults first
// - After init light tone, failsoft, keying indicators
// - Errors classed fatal (reset) or non-fatal (warning)
// - Early failures go to fault indicator only
// - Flash fixed count, then starve watchdog; unserviced while flashing too, default WDOG_CYC fires before the first flash
// - Later failures queued, sent after link verified
// - Fatal code: show five seconds, then reset
// - Non-fatal code: show, keep servicing, no reset
// - Order: stand-alone, system-level, then audio tests
// - Skip system and audio after watchdog reset
// - Tone indicator off when stand-alone tests begin
// - RAM toggle test; failure flashes four times
// - Byte interrupt per bus byte, about 322.1 us
// - Missing byte interrupt flashes twice, then reset
// - Ring clock half E, sync every 40 clocks
// - Bus strobe 3105 Hz square, address driven
// - Address nibble advances modulo 16
// - Bus clock E is 1.9872 MHz square wave; e_clk_out toggles every E_HALF_CYC (12) clocks, about 2.083 MHz
// - Uncorrected fatal fault fails identically every restart
// - Module never drives the shared reset
// - Watchdog timeout gives about two E cycle pulse
package sdf_pkg;
   localparam int          CLK_HZ         = 50000000;
   localparam int          E_HZ           = 1987200;
   // E half period in clk cycles, rounded down
   localparam int          E_HALF_CYC     = CLK_HZ / (2 * E_HZ);
   localparam int          STROBE_HZ      = 3105;
   localparam int          STROBE_HALF_CYC = CLK_HZ / (2 * STROBE_HZ);
   localparam int          BYTE_PERIOD_NS = 322100;
   localparam int          BYTE_PERIOD_CYC = BYTE_PERIOD_NS / 20;
   localparam int          RING_LEN       = 40;
   localparam int          SHOW_SEC       = 5;
   localparam int          SHOW_CYC       = SHOW_SEC * CLK_HZ;
   localparam int          WDOG_CYC       = 100000;
   localparam int          WDOG_PULSE_CYC = 2 * E_HALF_CYC * 2;
   localparam int          FLASH_HALF_CYC = 5000000;
   localparam int          IRQ_WAIT_CYC   = 2 * BYTE_PERIOD_CYC;
   localparam int          RAM_DEPTH      = 16;
   localparam int          Q_DEPTH        = 8;
   localparam logic [3:0]  FLASH_RAM      = 4'h4;
   localparam logic [3:0]  FLASH_IRQ      = 4'h2;
   localparam logic [7:0]  CODE_FATAL_BIT = 8'h80;
   localparam logic [7:0]  CODE_SYS       = 8'h81;
   localparam logic [7:0]  CODE_AUDIO     = 8'h02;
   localparam int          BAUD_DIV       = 434;
endpackage : sdf_pkg

// file: common/sdf_link_if.sv
// Shared pins between the add-on module and the station controller.
// Assumes both ends share clk_in; the bench resolves the reset wire.
`timescale 1ns/1ps
`default_nettype none
interface sdf_link_if;
   logic       mod_reset_n;     // Shared module reset, controller drives
   logic       ring_clock;
   logic       ring_frame_sync;
   logic       bus_strobe_n;
   logic [3:0] bus_address_nibble;
   logic       ser_valid;       // Serial link code strobe, module to ctrl
   logic [7:0] ser_code;
   logic       ser_ready;       // Controller accepts a code
   logic       link_ok;         // Controller echoes presence on link

   modport device_mp (input mod_reset_n, ring_clock, ring_frame_sync,
                      bus_strobe_n, bus_address_nibble, ser_ready, link_ok,
                      output ser_valid, ser_code);
   modport ctrl_mp (output mod_reset_n, ring_clock, ring_frame_sync,
                    bus_strobe_n, bus_address_nibble, ser_ready, link_ok,
                    input ser_valid, ser_code);
endinterface : sdf_link_if
`default_nettype wire

// file: src/sdf_ctrl.sv
// Station controller end: ring timing, bus strobe, code display.
// Assumes the bench ties local power-on reset and ctrl_tests_done_in.
`timescale 1ns/1ps
`default_nettype none
module sdf_ctrl
   import sdf_pkg::*;
   #(parameter int SHOW_CYCLES = SHOW_CYC)
   (input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       ce_in,
    input  wire logic       ctrl_tests_done_in,
    sdf_link_if.ctrl_mp     link,
    output logic      [7:0] shown_code_out,
    output logic            showing_out);

   logic [7:0]  rdiv_reg, rdiv_next;
   logic [5:0]  rcnt_reg, rcnt_next;
   logic        rclk_reg, rclk_next, sync_reg, sync_next;
   logic        strb_reg, strb_next;
   logic [15:0] sdv_reg, sdv_next;
   logic [3:0]  addr_reg, addr_next;
   logic [31:0] show_reg, show_next;
   logic [7:0]  code_reg, code_next;
   logic        fatal_reg, fatal_next, hold_reg, hold_next;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      rdiv_next = rdiv_reg + 8'h01;
      rclk_next = rclk_reg;
      rcnt_next = rcnt_reg;
      sync_next = sync_reg;
      sdv_next  = sdv_reg + 16'h0001;
      strb_next = strb_reg;
      addr_next = addr_reg;
      show_next = show_reg;
      code_next = code_reg;
      fatal_next = fatal_reg;
      hold_next = hold_reg | ~ctrl_tests_done_in;
      if (ctrl_tests_done_in)
         hold_next = 1'b0;
      // Ring clock at half E: toggle every E period
      if (rdiv_reg == 8'(2 * E_HALF_CYC - 1))
      begin
         rdiv_next = 8'h00;
         rclk_next = ~rclk_reg;
         if (rclk_reg)
         begin
            rcnt_next = (rcnt_reg == 6'(RING_LEN - 1)) ? 6'h00
                        : rcnt_reg + 6'h01;
            sync_next = (rcnt_reg == 6'(RING_LEN - 1));
         end
      end
      if (sdv_reg == 16'(STROBE_HALF_CYC - 1))
      begin
         sdv_next  = 16'h0000;
         strb_next = ~strb_reg;
         if (!strb_reg)
            addr_next = addr_reg + 4'h1;
      end
      if (show_reg != 32'h0)
         show_next = show_reg - 32'h1;
      // Fatal flag ends with the one-cycle reset pulse
      if (show_reg == 32'h1)
         fatal_next = 1'b0;
      if (link.ser_valid)
      begin
         code_next  = link.ser_code;
         fatal_next = |(link.ser_code & CODE_FATAL_BIT);
         show_next  = 32'(SHOW_CYCLES);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rdiv_reg <= 8'h00; rclk_reg <= 1'b0; rcnt_reg <= 6'h00;
         sync_reg <= 1'b0; sdv_reg <= 16'h0000; strb_reg <= 1'b1;
         addr_reg <= 4'h0; show_reg <= 32'h0; code_reg <= 8'h00;
         fatal_reg <= 1'b0; hold_reg <= 1'b1;
      end
      else if (ce_in)
      begin
         rdiv_reg <= rdiv_next; rclk_reg <= rclk_next; rcnt_reg <= rcnt_next;
         sync_reg <= sync_next; sdv_reg <= sdv_next; strb_reg <= strb_next;
         addr_reg <= addr_next; show_reg <= show_next; code_reg <= code_next;
         fatal_reg <= fatal_next; hold_reg <= hold_next;
      end
   end

   // Fatal code: reset module in the last cycle of the display window
   assign link.mod_reset_n = ~(hold_reg | (fatal_reg && show_reg == 32'h1));
   assign link.ring_clock = rclk_reg;
   assign link.ring_frame_sync = sync_reg;
   assign link.bus_strobe_n = strb_reg;
   assign link.bus_address_nibble = addr_reg;
   // One code per display window; low in the valid cycle so that no
   // second code slips in before the window starts
   assign link.ser_ready = ~hold_reg & ~link.ser_valid
                           & (show_reg == 32'h0);
   assign link.link_ok = ~hold_reg;
   assign shown_code_out = code_reg;
   assign showing_out = (show_reg != 32'h0);
endmodule : sdf_ctrl
`default_nettype wire

// file: src/sdf_device.sv
// Add-on module self-test sequencer with fault reporting.
// Assumes the link interface is driven by the controller end.
`timescale 1ns/1ps
`default_nettype none
module sdf_device
   import sdf_pkg::*;
   #(parameter int WDOG_CYCLES  = WDOG_CYC,
     parameter int FLASH_CYCLES = FLASH_HALF_CYC)
   (input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    input  wire logic  ce_in,
    input  wire logic  ram_fault_in,    // Injected RAM stuck bit
    input  wire logic  sys_fault_in,    // System-level test fails
    input  wire logic  audio_fault_in,  // Audio test fails (warning)
    sdf_link_if.device_mp link,
    output logic       fault_ind_out,
    output logic       tone_ind_out,
    output logic       failsoft_ind_out,
    output logic       keying_ind_out,
    output logic       e_clk_out,
    output logic       bus_irq_out,
    output logic       done_out);

   typedef enum logic [3:0] {
      ST_HOLD  = 4'h0, ST_INIT = 4'h1, ST_RAM  = 4'h2, ST_IRQ = 4'h3,
      ST_SYS   = 4'h4, ST_AUD  = 4'h5, ST_SEND = 4'h6, ST_FLASH = 4'h7,
      ST_STALL = 4'h8, ST_DONE = 4'h9} sdf_state_type;

   sdf_state_type state_reg, state_next;
   logic [1:0]  rsy_reg;          // Shared reset synchroniser
   logic [1:0]  stb_reg;          // Strobe synchroniser
   logic        stb_d_reg;
   logic [7:0]  ediv_reg;
   logic        e_reg;
   logic [3:0]  ridx_reg, ridx_next;
   logic [7:0]  ram_reg [RAM_DEPTH];
   logic [7:0]  q_reg [Q_DEPTH];
   logic [2:0]  qw_reg, qw_next, qr_reg, qr_next;
   logic [31:0] cnt_reg, cnt_next, wd_reg;
   logic [3:0]  fl_reg, fl_next;
   logic        fault_reg, fault_next, tone_reg, tone_next;
   logic        side_reg, side_next, irq_seen_reg, irq_seen_next;
   logic        wdog_boot_reg;   // Last restart came from own watchdog
   logic        wd_fire;
   logic        irq_pulse;
   logic        q_push;
   logic [7:0]  q_din;
   logic [7:0]  code_reg;
   logic        sv_reg;

   // Toggle pattern for a RAM cell
   function automatic logic [7:0] sdf_tog(input logic [7:0] v, input logic f);
      sdf_tog = f ? (v | 8'h01) : v;
   endfunction : sdf_tog

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, bus clock and byte interrupt
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rsy_reg <= 2'b00; stb_reg <= 2'b11; stb_d_reg <= 1'b1;
         ediv_reg <= 8'h00; e_reg <= 1'b0;
      end
      else if (ce_in)
      begin
         rsy_reg <= {rsy_reg[0], link.mod_reset_n};
         stb_reg <= {stb_reg[0], link.bus_strobe_n};
         stb_d_reg <= stb_reg[1];
         ediv_reg <= (ediv_reg == 8'(E_HALF_CYC - 1)) ? 8'h00
                     : ediv_reg + 8'h01;
         if (ediv_reg == 8'(E_HALF_CYC - 1))
            e_reg <= ~e_reg;
      end
   end
   // One byte lands per strobe falling edge
   assign irq_pulse = stb_d_reg & ~stb_reg[1];

   ////////////////////////////////////////////////////////////////////////
   // Watchdog: serviced except while flashing/stalling
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wd_reg <= 32'h0; wdog_boot_reg <= 1'b0;
      end
      else if (ce_in)
      begin
         if (state_reg == ST_FLASH || state_reg == ST_STALL)
            wd_reg <= wd_reg + 32'h1;
         else if (wd_reg >= 32'(WDOG_CYCLES))
            wd_reg <= (wd_reg == 32'(WDOG_CYCLES + WDOG_PULSE_CYC)) ? 32'h0
                      : wd_reg + 32'h1;
         else
            wd_reg <= 32'h0;
         if (wd_fire)
            wdog_boot_reg <= 1'b1;
         else if (!rsy_reg[1])
            wdog_boot_reg <= 1'b0;
      end
   end
   assign wd_fire = (wd_reg >= 32'(WDOG_CYCLES));

   ////////////////////////////////////////////////////////////////////////
   // Sequencer next state
   always_comb
   begin
      state_next = state_reg;
      ridx_next = ridx_reg; qw_next = qw_reg; qr_next = qr_reg;
      cnt_next = cnt_reg; fl_next = fl_reg; fault_next = fault_reg;
      tone_next = tone_reg; side_next = side_reg;
      irq_seen_next = irq_seen_reg | irq_pulse;
      q_push = 1'b0; q_din = 8'h00;
      case (state_reg)
         ST_HOLD:
            if (rsy_reg[1])
               state_next = ST_INIT;
         ST_INIT:
         begin
            side_next = 1'b1;
            state_next = ST_RAM;
            ridx_next = 4'h0;
            tone_next = 1'b1;
         end
         ST_RAM:
         begin
            tone_next = 1'b0;
            if (sdf_tog(8'h00, 1'b1) != sdf_tog(8'h00, ~ram_fault_in))
            begin
               fl_next = FLASH_RAM;
               cnt_next = 32'h0;
               state_next = ST_FLASH;
            end
            else if (ridx_reg == 4'(RAM_DEPTH - 1))
            begin
               state_next = ST_IRQ;
               cnt_next = 32'h0;
               irq_seen_next = irq_pulse; // Set wins over clear
            end
            else
               ridx_next = ridx_reg + 4'h1;
         end
         ST_IRQ:
            if (irq_seen_reg)
               state_next = wdog_boot_reg ? ST_SEND : ST_SYS;
            else if (cnt_reg == 32'(IRQ_WAIT_CYC))
            begin
               fl_next = FLASH_IRQ;
               cnt_next = 32'h0;
               state_next = ST_FLASH;
            end
            else
               cnt_next = cnt_reg + 32'h1;
         ST_SYS:
         begin
            if (sys_fault_in)
            begin
               q_push = 1'b1; q_din = CODE_SYS;
            end
            state_next = ST_AUD;
         end
         ST_AUD:
         begin
            if (audio_fault_in)
            begin
               q_push = 1'b1; q_din = CODE_AUDIO;
            end
            state_next = ST_SEND;
         end
         ST_SEND:
            if (qr_reg == qw_reg)
               state_next = ST_DONE;
            else if (link.link_ok && link.ser_ready)
               qr_next = qr_reg + 3'h1;
         ST_FLASH:
         begin
            cnt_next = cnt_reg + 32'h1;
            if (cnt_reg == 32'(FLASH_CYCLES - 1))
            begin
               cnt_next = 32'h0;
               fault_next = ~fault_reg;
               if (fault_reg)
               begin
                  fl_next = fl_reg - 4'h1;
                  if (fl_reg == 4'h1)
                     state_next = ST_STALL;
               end
            end
         end
         ST_STALL:
            fault_next = 1'b1;
         ST_DONE:
            fault_next = 1'b0;
         default:
            state_next = ST_HOLD;
      endcase
      if (q_push)
         qw_next = qw_reg + 3'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer registers; own watchdog or shared reset restarts it
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_reg <= ST_HOLD; ridx_reg <= 4'h0; qw_reg <= 3'h0;
         qr_reg <= 3'h0; cnt_reg <= 32'h0; fl_reg <= 4'h0;
         fault_reg <= 1'b1; tone_reg <= 1'b0; side_reg <= 1'b0;
         irq_seen_reg <= 1'b0; code_reg <= 8'h00; sv_reg <= 1'b0;
      end
      else if (ce_in)
      begin
         if (!rsy_reg[1] || wd_fire)
         begin
            state_reg <= ST_HOLD; ridx_reg <= 4'h0; qw_reg <= 3'h0;
            qr_reg <= 3'h0; fault_reg <= 1'b1; side_reg <= 1'b0;
            tone_reg <= 1'b0; cnt_reg <= 32'h0; sv_reg <= 1'b0;
         end
         else
         begin
            state_reg <= state_next; ridx_reg <= ridx_next;
            qw_reg <= qw_next; qr_reg <= qr_next; cnt_reg <= cnt_next;
            fl_reg <= fl_next; fault_reg <= fault_next;
            tone_reg <= tone_next;
            side_reg <= side_next; irq_seen_reg <= irq_seen_next;
            sv_reg <= (state_reg == ST_SEND) && (qr_reg != qw_reg)
                      && link.link_ok && link.ser_ready;
            code_reg <= q_reg[qr_reg];
         end
      end
   end

   // Queue storage and RAM image
   always_ff @(posedge clk_in)
   begin
      if (ce_in && q_push)
         q_reg[qw_reg] <= q_din;
      if (ce_in && state_reg == ST_RAM)
         ram_reg[ridx_reg] <= 8'h00;
   end

   assign fault_ind_out = fault_reg;
   assign tone_ind_out = tone_reg;
   assign failsoft_ind_out = side_reg;
   assign keying_ind_out = side_reg;
   assign e_clk_out = e_reg;
   assign bus_irq_out = irq_pulse;
   assign done_out = (state_reg == ST_DONE);
   assign link.ser_valid = sv_reg;
   assign link.ser_code = code_reg;
   // no output of this module drives the shared reset
endmodule : sdf_device
`default_nettype wire

// file: verification/sdf_link_checker.sv
// Concurrent checks on the shared pins between module and controller.
// Assumes the bench instantiates it beside the link interface instance.
`timescale 1ns/1ps
`default_nettype none
module sdf_link_checker
   import sdf_pkg::*;
   #(parameter int SHOW_CYCLES = SHOW_CYC)
   (input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       ce_in,
    input  wire logic       ctrl_tests_done_in,
    input  wire logic       mod_reset_n,
    input  wire logic       ring_clock,
    input  wire logic       ring_frame_sync,
    input  wire logic       bus_strobe_n,
    input  wire logic [3:0] bus_address_nibble,
    input  wire logic       ser_valid,
    input  wire logic [7:0] ser_code,
    input  wire logic       ser_ready,
    input  wire logic       link_ok);

   localparam int RC_HALF = 2 * E_HALF_CYC;
   localparam int SHOW_LO = SHOW_CYCLES - 2;
   localparam int SHOW_HI = SHOW_CYCLES + 8;

   ////////////////////////////////////////////////////////////////////////
   logic       rc_reg, sy_reg, st_reg;
   logic [1:0] rc_n_reg, rc_n_next, sy_n_reg, sy_n_next, st_n_reg, st_n_next;
   int         rc_cnt_reg, rc_cnt_next, sy_cnt_reg, sy_cnt_next;
   int         st_cnt_reg, st_cnt_next;
   logic       rc_chg, rc_rise, sy_rise, st_chg;

   assign rc_chg  = ring_clock != rc_reg;
   assign rc_rise = ring_clock & ~rc_reg;
   assign sy_rise = ring_frame_sync & ~sy_reg;
   assign st_chg  = bus_strobe_n != st_reg;

   // Edge counters; two edges seen first, so the reset edge is not judged
   always_comb
   begin
      rc_cnt_next = rc_chg ? 0 : rc_cnt_reg + 1;
      st_cnt_next = st_chg ? 0 : st_cnt_reg + 1;
      sy_cnt_next = sy_rise ? 0 : sy_cnt_reg + int'(rc_rise);
      rc_n_next = (rc_chg && rc_n_reg != 2'h2) ? rc_n_reg + 2'h1 : rc_n_reg;
      st_n_next = (st_chg && st_n_reg != 2'h2) ? st_n_reg + 2'h1 : st_n_reg;
      sy_n_next = (sy_rise && sy_n_reg != 2'h2) ? sy_n_reg + 2'h1 : sy_n_reg;
   end

   // Registers of the edge counters
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         {rc_reg, sy_reg, st_reg} <= 3'h0;
         {rc_n_reg, sy_n_reg, st_n_reg} <= 6'h00;
         {rc_cnt_reg, sy_cnt_reg, st_cnt_reg} <= '0;
      end
      else if (ce_in)
      begin
         {rc_reg, sy_reg, st_reg} <= {ring_clock, ring_frame_sync, bus_strobe_n};
         {rc_n_reg, sy_n_reg, st_n_reg} <= {rc_n_next, sy_n_next, st_n_next};
         rc_cnt_reg <= rc_cnt_next;
         sy_cnt_reg <= sy_cnt_next;
         st_cnt_reg <= st_cnt_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence fatal_sent;
      ser_valid && ((ser_code & CODE_FATAL_BIT) != 8'h00);
   endsequence
   sequence show_hold;
      mod_reset_n [*8];
   endsequence

   AST_RING_HALF: assert property (rc_chg && rc_n_reg == 2'h2 |->
      rc_cnt_reg == RC_HALF - 1) else $error("ring clock half period");
   AST_SYNC_PERIOD: assert property (sy_rise && sy_n_reg == 2'h2 |->
      sy_cnt_reg + int'(rc_rise) == RING_LEN) else $error("sync spacing");
   AST_STROBE_HALF: assert property (st_chg && st_n_reg == 2'h2 |->
      st_cnt_reg == STROBE_HALF_CYC - 1) else $error("strobe half period");
   AST_NIBBLE_STEP: assert property ($changed(bus_address_nibble) |->
      bus_address_nibble == $past(bus_address_nibble) + 4'h1)
      else $error("address nibble step");
   AST_HOLD_RESET: assert property (!ctrl_tests_done_in |->
      !mod_reset_n) else $error("shared reset released early");
   AST_FATAL_HOLD: assert property (fatal_sent |=> show_hold)
      else $error("reset before display window");
   AST_FATAL_RESET: assert property (fatal_sent |->
      ##[SHOW_LO:SHOW_HI] !mod_reset_n) else $error("no reset after fatal");
   AST_SEND_LINK: assert property (ser_valid |->
      $past(ser_ready) && link_ok && mod_reset_n)
      else $error("code sent unready");

   COV_FATAL: cover property (fatal_sent);
endmodule : sdf_link_checker
`default_nettype wire

// file: verification/startup_diag_fail_reporting_bench.sv
// Self-checking bench joining device and controller over the link.
// Assumes both ends run on clk_in; device reset is power and shared.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
   err_count++; $display("unexpected %s exp %0h got %0h", nm, ex, gt); end end
module startup_diag_fail_reporting_bench;
   import sdf_pkg::*;
   typedef logic [7:0] sdf_code_q_type [$];
   localparam int WD = 200;
   localparam int FL = 4;
   localparam int SH = 50;
   localparam int LIMIT = 90000;

   logic           clk_in = 1'b0;
   logic           rst_n = 1'b0;
   logic           tests_done = 1'b0;
   logic           ram_f = 1'b0;
   logic           sys_f = 1'b0;
   logic           aud_f = 1'b0;
   logic           ctrl_ce = 1'b1;
   logic           tone_seen = 1'b0;
   wire logic      dev_rst_n;
   logic           fault, tone, fsoft, keying, eclk, irq, done, showing;
   logic [7:0]     shown;
   logic           strobe_q = 1'b1;
   logic           fault_q = 1'b1;
   int             err_count = 0;
   int             num_checks = 0;
   int             cyc = 0;
   int             falls, irqs, ffalls;
   sdf_code_q_type got_q;

   sdf_link_if u_sdf_link_if();
   assign dev_rst_n = rst_n & u_sdf_link_if.mod_reset_n;

   always #10 clk_in = ~clk_in;

   ////////////////////////////////////////////////////////////////////////
   sdf_ctrl #(.SHOW_CYCLES(SH)) u_sdf_ctrl
      (.clk_in(clk_in), .rst_n_in(rst_n), .ce_in(ctrl_ce),
       .ctrl_tests_done_in(tests_done), .link(u_sdf_link_if.ctrl_mp),
       .shown_code_out(shown), .showing_out(showing));
   sdf_device #(.WDOG_CYCLES(WD), .FLASH_CYCLES(FL)) u_sdf_device
      (.clk_in(clk_in), .rst_n_in(dev_rst_n), .ce_in(1'b1),
       .ram_fault_in(ram_f), .sys_fault_in(sys_f), .audio_fault_in(aud_f),
       .link(u_sdf_link_if.device_mp), .fault_ind_out(fault),
       .tone_ind_out(tone), .failsoft_ind_out(fsoft),
       .keying_ind_out(keying), .e_clk_out(eclk), .bus_irq_out(irq),
       .done_out(done));
   sdf_link_checker #(.SHOW_CYCLES(SH)) u_sdf_link_checker
      (.clk_in(clk_in), .rst_n_in(rst_n), .ce_in(ctrl_ce),
       .ctrl_tests_done_in(tests_done),
       .mod_reset_n(u_sdf_link_if.mod_reset_n),
       .ring_clock(u_sdf_link_if.ring_clock),
       .ring_frame_sync(u_sdf_link_if.ring_frame_sync),
       .bus_strobe_n(u_sdf_link_if.bus_strobe_n),
       .bus_address_nibble(u_sdf_link_if.bus_address_nibble),
       .ser_valid(u_sdf_link_if.ser_valid),
       .ser_code(u_sdf_link_if.ser_code),
       .ser_ready(u_sdf_link_if.ser_ready),
       .link_ok(u_sdf_link_if.link_ok));

   ////////////////////////////////////////////////////////////////////////
   // Collect codes, strobe falls, interrupts and indicator flashes
   always @(posedge clk_in)
   begin
      strobe_q <= u_sdf_link_if.bus_strobe_n;
      fault_q <= fault;
      if (tone === 1'b1)
         tone_seen <= 1'b1;
      if (u_sdf_link_if.ser_valid === 1'b1)
         got_q.push_back(u_sdf_link_if.ser_code);
      if (fault_q === 1'b1 && fault === 1'b0)
         ffalls++;
      if (dev_rst_n === 1'b1)
      begin
         if (strobe_q === 1'b1 && u_sdf_link_if.bus_strobe_n === 1'b0)
            falls++;
         if (irq === 1'b1)
            irqs++;
      end
   end

   // Hang guard; counts as a mismatch
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         err_count++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      if (err_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : tick

   // Codes that a clean shared-reset boot must send, in detection order
   function automatic sdf_code_q_type exp_codes(input bit s, input bit a);
      sdf_code_q_type q;
      if (s)
         q.push_back(CODE_SYS);
      if (a)
         q.push_back(CODE_AUDIO);
      return q;
   endfunction : exp_codes

   // Power reset, then controller finishes its own tests
   task automatic boot();
      rst_n = 1'b0;
      tests_done = 1'b0;
      tick(3);
      rst_n = 1'b1;
      tick(5);
      `CHK("shared reset held", 1'b0, u_sdf_link_if.mod_reset_n)
      `CHK("fault lit at start", 1'b1, fault)
      got_q.delete();
      falls = 0;
      irqs = 0;
      tone_seen = 1'b0;
      tests_done = 1'b1;
   endtask : boot

   task automatic wait_codes(input int lim);
      for (int i = 0; i < lim && got_q.size() == 0; i++) tick(1);
   endtask : wait_codes

   // RAM fault: four flashes, no codes; watchdog boot skips system tests
   task automatic run_ram();
      ram_f = 1'b1;
      sys_f = 1'b1;
      aud_f = 1'b0;
      boot();
      for (int i = 0; i < 40000 && fault !== 1'b0; i++) tick(1);
      ffalls = 0;
      tick(2 * FL * 4 + 60);
      ram_f = 1'b0;
      `CHK("flash count", 4, ffalls)
      `CHK("early codes", 0, got_q.size())
      `CHK("module reset idle", 1'b1, u_sdf_link_if.mod_reset_n)
      for (int i = 0; i < 40000 && done !== 1'b1; i++) tick(1);
      `CHK("watchdog boot done", 1'b1, done)
      `CHK("watchdog boot codes", 0, got_q.size())
   endtask : run_ram

   // Controller frozen, so no strobe: byte interrupt missing, two flashes
   task automatic run_irq();
      ram_f = 1'b0;
      sys_f = 1'b0;
      aud_f = 1'b0;
      boot();
      tick(1);
      ctrl_ce = 1'b0;
      for (int i = 0; i < 40000 && fault !== 1'b0; i++) tick(1);
      ffalls = 0;
      tick(2 * FL * 2 + 20);
      ctrl_ce = 1'b1;
      `CHK("irq flash count", 2, ffalls)
      `CHK("irq early codes", 0, got_q.size())
   endtask : run_irq

   task automatic run_codes(input bit s, input bit a);
      sdf_code_q_type q;
      int lows;
      q = exp_codes(s, a);
      sys_f = s;
      aud_f = a;
      boot();
      if (s)
      begin
         wait_codes(40000);
         for (int i = 0; i < SH + 20 && u_sdf_link_if.mod_reset_n === 1'b1; i++)
            tick(1);
         `CHK("fatal reset", 1'b0, u_sdf_link_if.mod_reset_n)
         `CHK("first code", CODE_SYS, got_q.size() > 0 ? got_q[0] : 8'h00)
         if (got_q.size() > 1)
            `CHK("second code", CODE_AUDIO, got_q[1])
         got_q.delete();
         wait_codes(40000);
         `CHK("repeat code", CODE_SYS, got_q.size() > 0 ? got_q[0] : 8'h00)
      end
      else
      begin
         for (int i = 0; i < 40000 && done !== 1'b1; i++) tick(1);
         tick(4);
         `CHK("done", 1'b1, done)
         `CHK("fault off at end", 1'b0, fault)
         `CHK("tone indicator", 1'b0, tone)
         `CHK("tone lit after init", 1'b1, tone_seen)
         `CHK("failsoft indicator", 1'b1, fsoft)
         `CHK("keying indicator", 1'b1, keying)
         `CHK("byte interrupts", falls, irqs)
         `CHK("code count", q.size(), got_q.size())
         for (int i = 0; i < q.size() && i < got_q.size(); i++)
            `CHK("code", q[i], got_q[i])
         lows = 0;
         for (int i = 0; i < 100; i++)
         begin
            tick(1);
            if (u_sdf_link_if.mod_reset_n !== 1'b1)
               lows++;
         end
         `CHK("no warning reset", 0, lows)
         if (a)
            `CHK("shown warning", CODE_AUDIO, shown)
      end
   endtask : run_codes

   ////////////////////////////////////////////////////////////////////////
   // Main sequence: corner cases first, then a run with a random audio fault
   initial
   begin
      void'($urandom(73133));
      run_ram();
      tick($urandom_range(20, 1));
      run_irq();
      tick($urandom_range(20, 1));
      run_codes(1'b1, 1'b1);
      tick($urandom_range(20, 1));
      run_codes(1'b0, 1'($urandom % 2));
      wrap_up();
   end
endmodule : startup_diag_fail_reporting_bench
`undef CHK
`default_nettype wire
